// ==== design/cfl_loader.sv ====
/*
  configuration flag default loader: reads the signature byte and three
  flag words from the nonvolatile store through a simple read port and
  drives the decoded fields as power-on defaults of the target registers.
  assumes the store answers each read request with one rvalid pulse, on
  the same clock; software may inspect and re-run the load over apb.
*/
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cfl_loader
  import cfl_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // nonvolatile store read port
  output logic             nv_req_o,
  output logic [7:0]       nv_addr_o,
  input  wire logic        nv_rvalid_i,
  input  wire logic [31:0] nv_rdata_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // defaults toward the target registers
  output cfl_interchip_t   interchip_o,
  output cfl_usb_t         usb_o,
  output cfl_mac_t         mac_o,
  output cfl_phy_t         phy_o,
  output cfl_system_t      system_o,
  output logic             defaults_valid_o
);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CFL_ST_SIG_REQ, CFL_ST_SIG_WAIT, CFL_ST_WORD_REQ, CFL_ST_WORD_WAIT, CFL_ST_IDLE
  } cfl_state_t;

  cfl_state_t  state;
  logic [1:0]  word_idx;
  logic        present;
  logic [31:0] word0;
  logic [31:0] word1;
  logic [31:0] word2;
  logic        reload;
  logic        apb_access;

  assign apb_access = psel_i & penable_i;
  // a write only takes effect on the edge that completes the transfer
  assign reload     = apb_access & pready_o & pwrite_i & (paddr_i == CFL_OFS_CONTROL) &
                      pwdata_i[CFL_CTL_RELOAD] & (state == CFL_ST_IDLE);

  // byte 0 holds the signature, words follow at byte 4, 8 and 12
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state     <= CFL_ST_SIG_REQ;
      word_idx  <= 2'h0;
      present   <= 1'b0;
      nv_req_o  <= 1'b0;
      nv_addr_o <= 8'h00;
    end else begin
      nv_req_o <= 1'b0;
      case (state)
        CFL_ST_SIG_REQ: begin
          nv_req_o  <= 1'b1;
          nv_addr_o <= 8'h00;
          state     <= CFL_ST_SIG_WAIT;
        end
        CFL_ST_SIG_WAIT: begin
          if (nv_rvalid_i) begin
            present  <= (nv_rdata_i[7:0] == CFL_SIGNATURE);
            word_idx <= 2'h0;
            // without a signature nothing more is read: defaults stay
            state    <= (nv_rdata_i[7:0] == CFL_SIGNATURE) ? CFL_ST_WORD_REQ
                                                           : CFL_ST_IDLE;
          end
        end
        CFL_ST_WORD_REQ: begin
          nv_req_o  <= 1'b1;
          nv_addr_o <= {4'h0, word_idx + 2'h1, 2'h0};
          state     <= CFL_ST_WORD_WAIT;
        end
        CFL_ST_WORD_WAIT: begin
          if (nv_rvalid_i) begin
            word_idx <= word_idx + 2'h1;
            state    <= (word_idx == CFL_WORD_COUNT - 2'h1) ? CFL_ST_IDLE
                                                           : CFL_ST_WORD_REQ;
          end
        end
        CFL_ST_IDLE: begin
          if (reload) begin
            state <= CFL_ST_SIG_REQ;
          end
        end
        default: begin
          state <= CFL_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // captured words, reserved bits masked off
  // ----------------------------------------------------------------
  // words are staged here and only published once all three arrived,
  // so consumers never see a half-loaded mix
  logic [31:0] stage0;
  logic [31:0] stage1;
  logic        capture;
  assign capture = (state == CFL_ST_WORD_WAIT) & nv_rvalid_i;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      stage0 <= CFL_WORD0_DEFAULT;
      stage1 <= CFL_WORD1_DEFAULT;
      word0  <= CFL_WORD0_DEFAULT;
      word1  <= CFL_WORD1_DEFAULT;
      word2  <= CFL_WORD2_DEFAULT;
    end else if (capture) begin
      case (word_idx)
        2'h0: stage0 <= nv_rdata_i & CFL_WORD0_USED;
        2'h1: stage1 <= nv_rdata_i & CFL_WORD1_USED;
        default: begin
          word0 <= stage0;
          word1 <= stage1;
          word2 <= nv_rdata_i & CFL_WORD2_USED;
        end
      endcase
    end
  end

  // consumers are held off until the sequence is over
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      defaults_valid_o <= 1'b0;
    end else if (reload) begin
      defaults_valid_o <= 1'b0;
    end else if (state == CFL_ST_IDLE) begin
      defaults_valid_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // field decode toward the target registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      interchip_o <= '0;
      usb_o       <= '0;
      mac_o       <= '0;
      phy_o       <= '0;
      system_o    <= '0;
    end else begin
      interchip_o.strobe_data_fifty_ohm_drive_en <= word0[31];
      interchip_o.strobe_data_slew_adjust        <= word0[30];
      usb_o.afe_squelch_adjust                   <= word0[29:27];
      interchip_o.interchip_pin_exchange         <= word0[21];
      usb_o.suspend_allow                        <= word0[20];
      system_o.suspend_out_select                <= word0[19:18];
      system_o.suspend_out_polarity              <= word0[17];
      mac_o.auto_duplex_detect                   <= word0[16];
      mac_o.auto_speed_detect                    <= word0[15];
      phy_o.phy_lowpower_sleep_interval          <= word0[14:13];
      phy_o.phy_lowpower_wake_interval           <= word0[12:11];
      phy_o.link_status_timeout_ctrl             <= word0[10:9];
      phy_o.phy_enhanced_lowpower_en             <= word0[8];
      usb_o.common_pll_link_pm_mode              <= word0[7];
      usb_o.hs_output_current                    <= word0[6:4];
      usb_o.port_exchange                        <= word0[3];
      usb_o.link_pm_capability                   <= word0[2];
      usb_o.remote_wake_support                  <= word0[1];
      usb_o.power_method_select                  <= word0[0];
      system_o.crystal_keep_running_in_suspend   <= word1[16];
      phy_o.transmit_swing_select                <= word1[6];
      phy_o.transmit_margin_select               <= word1[5:3];
      phy_o.transmit_deemph_select               <= word1[2:1];
      phy_o.elastic_buffer_mode                  <= word1[0];
      mac_o.energy_efficient_enable              <= word2[10];
      mac_o.eee_tx_clock_halt_en                 <= word2[11];
      mac_o.eee_tx_idle_auto_exit_en             <= word2[9];
      mac_o.auto_duplex_polarity                 <= word2[13];
      mac_o.duplex_select                        <= word2[8];
      mac_o.mac_speed_config                     <= word2[7:6];
      system_o.eee_linkup_accelerate             <= word2[12];
      usb_o.highspeed_timeout_trim               <= word2[5:3];
      usb_o.fullspeed_timeout_trim               <= word2[2:0];
    end
  end

  // ----------------------------------------------------------------
  // apb slave: one wait state, unmapped addresses answer pslverr
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;
  logic        next_err;

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    case (paddr_i)
      CFL_OFS_STATUS: begin
        next_prdata[CFL_ST_DONE]    = defaults_valid_o;
        next_prdata[CFL_ST_PRESENT] = present;
      end
      CFL_OFS_CONTROL: next_prdata = 32'h0000_0000;
      CFL_OFS_WORD0:   next_prdata = word0;
      CFL_OFS_WORD1:   next_prdata = word1;
      CFL_OFS_WORD2:   next_prdata = word2;
      default:         next_err    = 1'b1;
    endcase
  end

  // pready registered: each access phase lasts two cycles
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (apb_access & !pready_o) begin
      pready_o  <= 1'b1;
      pslverr_o <= next_err;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : next_prdata;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== design/cfl_pkg.sv ====
/*
  package of the configuration flag default loader: word layouts, field
  positions, register offsets and reset defaults.
  assumes a single 100 MHz clock domain and a synchronous active-low reset.
*/
// Operation
// - word0 bit 31 gives the fifty-ohm strobe/data drive enable default
// - word0 bit 30 gives the strobe/data slew adjust default
// - word0 bits 29:27 give the afe squelch adjust default
// - word0 bit 21 gives pin exchange, bit 20 gives suspend allow
// - word0 bits 19:18 give suspend output select, bit 17 its polarity
// - word0 bit 16 gives auto duplex detect, bit 15 auto speed detect
// - word0 bits 14:13 give the phy low-power sleep interval
// - word0 bits 12:11 give the phy low-power wake interval
// - word0 bits 10:9 give the two link status timeout control bits
// - word0 bit 8 set starts the phy in enhanced low-power mode
// - word0 bit 7 gives the common pll link power management mode
// - word0 bits 6:4 give the high-speed output current boost default
// - word0 bit 3 gives port exchange, bit 2 link pm capability
// - word0 bit 1 gives remote wake support, bit 0 power method
// - word1 bit 16 gives crystal keep running in suspend
// - word1 bits 6,5:3,2:1,0 give transmit swing, margin, de-emphasis, buffer mode
// - word2 bits 10,11,9 give eee enable, clock halt, idle auto exit
// - word2 bits 13,8,7:6 give duplex polarity, duplex, mac speed
// - word2 bit 12 gives eee link-up accelerate
// - word2 bits 5:3 give high-speed trim, 2:0 full-speed trim
// - without the signature at byte 0 keep the words already applied (hardware reset defaults after reset)
package cfl_pkg;

  // ----------------------------------------------------------------
  // store layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFL_SIGNATURE     = 8'ha5;
  localparam logic [1:0]  CFL_WORD_COUNT    = 2'h3;
  localparam logic [31:0] CFL_WORD0_USED    = 32'hf83f_ffff;
  localparam logic [31:0] CFL_WORD1_USED    = 32'h0001_007f;
  localparam logic [31:0] CFL_WORD2_USED    = 32'h0000_3fff;

  // ----------------------------------------------------------------
  // register map on apb (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFL_OFS_STATUS    = 8'h00;
  localparam logic [7:0]  CFL_OFS_CONTROL   = 8'h04;
  localparam logic [7:0]  CFL_OFS_WORD0     = 8'h08;
  localparam logic [7:0]  CFL_OFS_WORD1     = 8'h0c;
  localparam logic [7:0]  CFL_OFS_WORD2     = 8'h10;
  localparam int          CFL_CTL_RELOAD    = 0;
  localparam int          CFL_ST_DONE       = 0;
  localparam int          CFL_ST_PRESENT    = 1;

  // ----------------------------------------------------------------
  // hardware reset defaults of the applied words (arbitrary, neutral)
  // ----------------------------------------------------------------
  localparam logic [31:0] CFL_WORD0_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] CFL_WORD1_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] CFL_WORD2_DEFAULT = 32'h0000_0000;

  // ----------------------------------------------------------------
  // field carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       strobe_data_fifty_ohm_drive_en;
    logic       strobe_data_slew_adjust;
    logic       interchip_pin_exchange;
  } cfl_interchip_t;

  typedef struct packed {
    logic       suspend_allow;
    logic       port_exchange;
    logic       link_pm_capability;
    logic       remote_wake_support;
    logic       power_method_select;
    logic [2:0] highspeed_timeout_trim;
    logic [2:0] fullspeed_timeout_trim;
    logic [2:0] afe_squelch_adjust;
    logic [2:0] hs_output_current;
    logic       common_pll_link_pm_mode;
  } cfl_usb_t;

  typedef struct packed {
    logic       auto_duplex_detect;
    logic       auto_speed_detect;
    logic       auto_duplex_polarity;
    logic       energy_efficient_enable;
    logic       eee_tx_clock_halt_en;
    logic       eee_tx_idle_auto_exit_en;
    logic       duplex_select;
    logic [1:0] mac_speed_config;
  } cfl_mac_t;

  typedef struct packed {
    logic [1:0] phy_lowpower_sleep_interval;
    logic [1:0] phy_lowpower_wake_interval;
    logic [1:0] link_status_timeout_ctrl;
    logic       phy_enhanced_lowpower_en;
    logic       transmit_swing_select;
    logic [2:0] transmit_margin_select;
    logic [1:0] transmit_deemph_select;
    logic       elastic_buffer_mode;
  } cfl_phy_t;

  typedef struct packed {
    logic [1:0] suspend_out_select;
    logic       suspend_out_polarity;
    logic       eee_linkup_accelerate;
    logic       crystal_keep_running_in_suspend;
  } cfl_system_t;

endpackage

// ==== tb/cfl_store_model.sv ====
/* store model: nonvolatile flag store answering each read after a set latency.
   assumes the loader's clock and reset, one read outstanding at a time. */
`timescale 1ns/1ps
`default_nettype none
module cfl_store_model (
  // clock, reset and contents
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [3:0][31:0] mem_i,
  input  wire logic [3:0]       lat_i,
  // read port
  input  wire logic             nv_req_i,
  input  wire logic [7:0]       nv_addr_i,
  output logic                  nv_rvalid_o,
  output logic [31:0]           nv_rdata_o
);
  logic       busy;
  logic [3:0] cnt;
  logic [1:0] idx;
  // idle data flips every cycle so a stray sample never passes as a word
  always_ff @(posedge ref_clk_i) begin
    nv_rvalid_o <= 1'b0;
    nv_rdata_o  <= ~nv_rdata_o;
    if (!reset_n_i) begin
      busy       <= 1'b0;
      nv_rdata_o <= 32'h5a5a_0f0f;
    end else if (nv_req_i) begin
      busy <= 1'b1;
      cnt  <= lat_i;
      idx  <= nv_addr_i[3:2];
    end else if (busy && cnt == 4'h0) begin
      busy        <= 1'b0;
      nv_rvalid_o <= 1'b1;
      nv_rdata_o  <= mem_i[idx];
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/cfl_loader_checker.sv ====
/* checker of the flag loader: store read order, apb answer, sampled fields.
   assumes it is bound to cfl_loader, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module cfl_loader_checker
  import cfl_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        nv_req_o,
  input wire logic [7:0]  nv_addr_o,
  input wire logic        nv_rvalid_i,
  input wire logic [31:0] nv_rdata_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire cfl_usb_t    usb_o,
  input wire cfl_system_t system_o,
  input wire logic        defaults_valid_o
);
  logic [31:0] w0;
  logic [31:0] w1;
  // shadow of the words as they crossed the store port
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      w0 <= CFL_WORD0_DEFAULT;
      w1 <= CFL_WORD1_DEFAULT;
    end else if (nv_rvalid_i && nv_addr_o == 8'h04) w0 <= nv_rdata_i;
    else if (nv_rvalid_i && nv_addr_o == 8'h08) w1 <= nv_rdata_i;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_head; nv_rvalid_i && nv_addr_o == 8'h00; endsequence
  sequence s_sig_ok; s_head ##0 nv_rdata_i[7:0] == CFL_SIGNATURE; endsequence
  property p_req_pulse; nv_req_o |=> !nv_req_o; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("long store request");
  property p_req_after; nv_req_o && nv_addr_o != 8'h00 |-> $past(nv_rvalid_i, 2); endproperty
  a_req_after: assert property (p_req_after) else $error("read before answer");
  property p_sig_next; s_sig_ok |-> ##2 nv_req_o && nv_addr_o == 8'h04; endproperty
  a_sig_next: assert property (p_sig_next) else $error("word0 not read");
  property p_no_sig; s_head ##0 nv_rdata_i[7:0] != CFL_SIGNATURE |=> !nv_req_o [*4]; endproperty
  a_no_sig: assert property (p_no_sig) else $error("read without signature");
  property p_apb_ans; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("apb answer late");
  property p_err_rdy; pslverr_o |-> pready_o; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_squelch; defaults_valid_o |-> usb_o.afe_squelch_adjust == w0[29:27]; endproperty
  a_squelch: assert property (p_squelch) else $error("squelch default wrong");
  property p_xtal; defaults_valid_o |-> system_o.crystal_keep_running_in_suspend == w1[16];
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal default wrong");
endmodule
bind cfl_loader cfl_loader_checker u_chk (.ref_clk_i, .reset_n_i, .nv_req_o, .nv_addr_o,
  .nv_rvalid_i, .nv_rdata_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .usb_o,
  .system_o, .defaults_valid_o);
`default_nettype wire

// ==== tb/tb_config_flags_default_loader.sv ====
/* bench of the flag loader: power-on load, reloads, bad signature, mid-run reset.
   assumes cfl_store_model and the bound checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb_config_flags_default_loader
  import cfl_pkg::*;
;
  localparam int FW = $bits(cfl_interchip_t) + $bits(cfl_usb_t) + $bits(cfl_mac_t)
                    + $bits(cfl_phy_t) + $bits(cfl_system_t);
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, dv_q = 1'b0;
  logic req, rv, prdy, perr, dv;
  logic [7:0] addr, padr = 8'h00;
  logic [31:0] rd, prd, pwd = 32'h0, seed = 32'ha3c09520;
  logic [31:0] w [3];
  logic [3:0][31:0] mem = '0;
  logic [3:0] lat = 4'h0;
  cfl_interchip_t ic; cfl_usb_t us; cfl_mac_t ma; cfl_phy_t ph; cfl_system_t sy;
  logic [FW-1:0] exp_q [$];
  int failures = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  cfl_loader uut (.ref_clk_i(clk), .reset_n_i(rst_n), .nv_req_o(req), .nv_addr_o(addr),
    .nv_rvalid_i(rv), .nv_rdata_i(rd), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .interchip_o(ic), .usb_o(us), .mac_o(ma), .phy_o(ph), .system_o(sy),
    .defaults_valid_o(dv));
  cfl_store_model u_store (.ref_clk_i(clk), .reset_n_i(rst_n), .mem_i(mem), .lat_i(lat),
    .nv_req_i(req), .nv_addr_i(addr), .nv_rvalid_o(rv), .nv_rdata_o(rd));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c1_1db7 : 32'h0);
    return seed;
  endfunction
  function automatic logic [FW-1:0] exp_f(input logic [31:0] a, b, c);
    cfl_interchip_t i; cfl_usb_t u; cfl_mac_t m; cfl_phy_t p; cfl_system_t s;
    i = '{a[31], a[30], a[21]};
    u = '{a[20], a[3], a[2], a[1], a[0], c[5:3], c[2:0],
          a[29:27], a[6:4], a[7]};
    m = '{a[16], a[15], c[13], c[10], c[11], c[9], c[8], c[7:6]};
    p = '{a[14:13], a[12:11], a[10:9], a[8], b[6], b[5:3], b[2:1], b[0]};
    s = '{a[19:18], a[17], c[12], b[16]};
    return {i, u, m, p, s};
  endfunction
  task automatic mism(input string m);
    failures++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  // master holds the whole request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge clk);
    {psel, pen, pwr, padr, pwd} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 50);
    r = prd;
    e = perr;
    {psel, pen} <= 2'b00;
    if (n >= 50) mism("apb hang");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r; logic e;
    apb(1'b0, a, 32'h0, r, e);
    total_checks++;
    if (e !== xe || (!xe && r !== x)) mism("register read");
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1'b1, a, d, r, e);
    total_checks++;
    if (e !== 1'b0) mism("write refused");
  endtask
  task automatic chk_regs(input logic [31:0] st);
    rd_chk(CFL_OFS_STATUS, st, 1'b0);
    rd_chk(CFL_OFS_WORD0, w[0] & CFL_WORD0_USED, 1'b0);
    rd_chk(CFL_OFS_WORD1, w[1] & CFL_WORD1_USED, 1'b0);
    rd_chk(CFL_OFS_WORD2, w[2] & CFL_WORD2_USED, 1'b0);
  endtask
  // stored words are chosen to agree with the descriptors in use
  task automatic load(input logic [7:0] sig, input logic [31:0] a, b, c);
    mem <= {c, b, a, {24'h0, sig}};
    if (sig == CFL_SIGNATURE) w = '{a, b, c};
    exp_q.push_back(exp_f(w[0], w[1], w[2]));
  endtask
  task automatic wait_done();
    int n = 0;
    while (dv === 1'b1 && n < 20) begin @(posedge clk); n++; end
    while (dv !== 1'b1 && n < 500) begin @(posedge clk); n++; end
    if (n >= 500) mism("load never finished");
    repeat (2) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // scoreboard: each finished load takes the oldest expected field set
  always @(negedge clk) begin
    if (dv === 1'b1 && !dv_q) begin
      total_checks++;
      if (exp_q.size() == 0 || {ic, us, ma, ph, sy} !== exp_q[0]) mism("fields");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    dv_q = (dv === 1'b1);
  end
  initial begin
    repeat (20000) @(posedge clk);
    mism("watchdog");
    complete_run();
  end
  initial begin
    w = '{CFL_WORD0_DEFAULT, CFL_WORD1_DEFAULT, CFL_WORD2_DEFAULT};
    load(CFL_SIGNATURE, rnd(), rnd(), rnd());
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_done();
    chk_regs(32'h3);
    for (int k = 0; k < 3; k++) begin
      lat <= 4'(k * 5);
      if (k == 1) load(CFL_SIGNATURE, '1, '1, '1);
      else load(CFL_SIGNATURE, rnd(), rnd(), rnd());
      wr_chk(CFL_OFS_CONTROL, 32'h1);
      wait_done();
      chk_regs(32'h3);
    end
    load(8'h5a, rnd(), rnd(), rnd());
    wr_chk(CFL_OFS_CONTROL, 32'h1);
    wait_done();
    chk_regs(32'h1);
    rd_chk(8'h40, 32'h0, 1'b1);
    rd_chk(CFL_OFS_CONTROL, 32'h0, 1'b0);
    wr_chk(CFL_OFS_WORD0, 32'hffff_ffff);
    chk_regs(32'h1);
    w = '{CFL_WORD0_DEFAULT, CFL_WORD1_DEFAULT, CFL_WORD2_DEFAULT};
    load(8'h00, rnd(), rnd(), rnd());
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_done();
    chk_regs(32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
